/* File: rtl/sbt_tap.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sbt_consts.svh"

// Behaviour
// [RL1] inputs taken at tck rise, outputs changed only at tck fall; mem_out_hiz and tap_in_reset follow the rise
// [RL2] tms steers controller at rise; tms and tdi idle high
// [RL3] serial data enters at msb, leaves from lsb
// [RL4] tdo driven only in shift states, floating from reset
// [RL5] five tms-high rising edges reach reset without touching memory
// [RL6] one register between tdi and tdo, chosen by held instruction
// [RL7] three-bit instruction, identification after power-up and reset state
// [RL8] capture-ir loads 01 into the two low instruction bits
// [RL9] bypass is one bit, cleared when bypass executes
// [RL10] boundary register captures pins, then shifts in shift-dr
// [RL11] identification instruction captures fixed 32-bit code and shifts it
// [RL12] the controller never loads the three reserved codes; the code loads them at update-ir and runs them as bypass
// [RL13] instruction shifted in shift-ir, takes effect at update-ir
// [RL14] no drive or preload into memory; such instructions only capture
// [RL15] all-zero instruction acts as sample and floats memory outputs
// [RL16] identification code comes out on tdo in shift-dr
// [RL17] floated sample shifts boundary register and floats memory outputs
// [RL18] sample captures all input and two-way pins at capture-dr
// [RL19] update-dr under sample does nothing, like pause-dr
// [RL20] test clock kept at or below 20 MHz
// [RL21] bypass instruction puts only the bypass bit in shift-dr path
// [RL22] boundary length 71, 52 or 110 bits by width variant
// [RL23] bit 0 of identification code reads one
// [RL24] sixteen-state controller steered by tms at each rising edge

// ==========================================================
// small fifo between rising-edge logic and falling-edge output
module sbt_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = `SBT_FIFO_DEPTH
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  wire              push;
  wire              pop;
  wire  [AW-1:0]    next_wr_ptr;
  wire  [AW-1:0]    next_rd_ptr;

  assign in_ready    = (count != FULL_CNT);
  assign out_valid   = (count != '0);
  assign out_data    = mem[rd_ptr];
  assign push        = in_valid && in_ready;
  assign pop         = out_valid && out_ready;
  assign next_wr_ptr = (wr_ptr == LAST_IDX) ? '0 : wr_ptr + 1'b1;
  assign next_rd_ptr = (rd_ptr == LAST_IDX) ? '0 : rd_ptr + 1'b1;

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= next_wr_ptr;
      end
      if (pop) begin
        rd_ptr <= next_rd_ptr;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule

// ==========================================================
// test access port
module sbt_tap #(
  // [RL22] boundary length
  parameter int                     BSR_LEN = `SBT_BSR_LEN_X36,
  parameter logic [`SBT_ID_LEN-1:0] ID_CODE = `SBT_ID_CODE_DEFAULT
) (
  input  wire logic               ref_clk,
  input  wire logic               rst,
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  input  wire logic [BSR_LEN-1:0] io_ring,
  output logic                    tdo,
  output logic                    tdo_oe,
  output logic                    mem_out_hiz,
  output logic                    tap_in_reset
);
  import sbt_pkg::*;

  localparam int IRL = `SBT_IR_LEN;
  localparam int IDL = `SBT_ID_LEN;

  // ========================================================
  // pin synchronisers
  // tms and tdi rest high so a floating pin reads as one
  localparam sbt_pins_t PIN_IDLE = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

  sbt_pins_t          pin_s1;
  sbt_pins_t          pin_s2;
  logic               tck_d;
  logic [BSR_LEN-1:0] ring_s1;
  logic [BSR_LEN-1:0] ring_s2;

  // [RL2] idle-high pins
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pin_s1 <= PIN_IDLE;
      pin_s2 <= PIN_IDLE;
      tck_d  <= 1'b0;
    end else begin
      pin_s1 <= '{tck: tck, tms: tms, tdi: tdi};
      pin_s2 <= pin_s1;
      tck_d  <= pin_s2.tck;
    end
  end

  // ring values are only stable if the memory side holds them still
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ring_s1 <= '0;
      ring_s2 <= '0;
    end else begin
      ring_s1 <= io_ring;
      ring_s2 <= ring_s1;
    end
  end

  // ========================================================
  // edge detection
  // [RL20] slow test clock
  // each tck phase must span several ref_clk cycles or edges merge
  wire tck_rise;
  wire tck_fall;
  assign tck_rise = pin_s2.tck && !tck_d;
  assign tck_fall = !pin_s2.tck && tck_d;

  logic rise_pend;
  logic tms_hold;
  logic tdi_hold;
  wire  work;
  wire  step;
  wire  fifo_in_ready;
  wire  tms_use;
  wire  tdi_use;

  // a rising edge waits here while the output queue is full
  assign work    = tck_rise || rise_pend;
  assign step    = work && fifo_in_ready;
  // [RL1] sample at rise
  assign tms_use = tck_rise ? pin_s2.tms : tms_hold;
  assign tdi_use = tck_rise ? pin_s2.tdi : tdi_hold;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rise_pend <= 1'b0;
      tms_hold  <= 1'b1;
      tdi_hold  <= 1'b1;
    end else begin
      rise_pend <= work && !fifo_in_ready;
      if (tck_rise) begin
        tms_hold <= pin_s2.tms;
        tdi_hold <= pin_s2.tdi;
      end
    end
  end

  // ========================================================
  // controller
  sbt_state_t state;
  sbt_state_t next_state;
  sbt_state_t move_state;

  // [RL24] standard sequence
  always_comb begin
    move_state = state;
    case (state)
      SBT_TLR:    move_state = tms_use ? SBT_TLR    : SBT_RTI;
      SBT_RTI:    move_state = tms_use ? SBT_SEL_DR : SBT_RTI;
      SBT_SEL_DR: move_state = tms_use ? SBT_SEL_IR : SBT_CAP_DR;
      SBT_CAP_DR: move_state = tms_use ? SBT_EX1_DR : SBT_SH_DR;
      SBT_SH_DR:  move_state = tms_use ? SBT_EX1_DR : SBT_SH_DR;
      SBT_EX1_DR: move_state = tms_use ? SBT_UPD_DR : SBT_PA_DR;
      SBT_PA_DR:  move_state = tms_use ? SBT_EX2_DR : SBT_PA_DR;
      SBT_EX2_DR: move_state = tms_use ? SBT_UPD_DR : SBT_SH_DR;
      SBT_UPD_DR: move_state = tms_use ? SBT_SEL_DR : SBT_RTI;
      // [RL5] tms high walks every state to reset within five edges
      SBT_SEL_IR: move_state = tms_use ? SBT_TLR    : SBT_CAP_IR;
      SBT_CAP_IR: move_state = tms_use ? SBT_EX1_IR : SBT_SH_IR;
      SBT_SH_IR:  move_state = tms_use ? SBT_EX1_IR : SBT_SH_IR;
      SBT_EX1_IR: move_state = tms_use ? SBT_UPD_IR : SBT_PA_IR;
      SBT_PA_IR:  move_state = tms_use ? SBT_EX2_IR : SBT_PA_IR;
      SBT_EX2_IR: move_state = tms_use ? SBT_UPD_IR : SBT_SH_IR;
      SBT_UPD_IR: move_state = tms_use ? SBT_SEL_DR : SBT_RTI;
      default:    move_state = SBT_TLR;
    endcase
  end

  assign next_state = step ? move_state : state;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= SBT_TLR;
    end else begin
      state <= next_state;
    end
  end

  // ========================================================
  // instruction decode
  logic [IRL-1:0] instr;
  logic [IRL-1:0] ir_sr;
  wire            sel_id;
  wire            sel_bsr;
  wire            sel_byp;
  wire            float_out;

  // [RL14] extest only captures, never drives
  assign sel_bsr   = (instr == `SBT_INS_EXTEST) ||
                     (instr == `SBT_INS_SAMPLE) ||
                     (instr == `SBT_INS_SAMPLE_Z);
  assign sel_id    = (instr == `SBT_INS_IDCODE);
  // [RL12] reserved codes fall back to the bypass path
  assign sel_byp   = !sel_bsr && !sel_id;
  // [RL15] all-zero floats outputs
  // [RL17] floated sample floats outputs
  assign float_out = (instr == `SBT_INS_EXTEST) ||
                     (instr == `SBT_INS_SAMPLE_Z);

  // ========================================================
  // scan registers
  logic               bypass_bit;
  logic [IDL-1:0]     id_sr;
  logic [BSR_LEN-1:0] bsr;

  logic [IRL-1:0]     next_instr;
  logic [IRL-1:0]     next_ir_sr;
  logic               next_bypass_bit;
  logic [IDL-1:0]     next_id_sr;
  logic [BSR_LEN-1:0] next_bsr;

  always_comb begin
    next_instr      = instr;
    next_ir_sr      = ir_sr;
    next_bypass_bit = bypass_bit;
    next_id_sr      = id_sr;
    next_bsr        = bsr;
    if (step) begin
      case (state)
        // [RL8] fixed capture pattern
        SBT_CAP_IR: next_ir_sr = `SBT_IR_CAPTURE;
        // [RL3] enter at msb
        SBT_SH_IR:  next_ir_sr = {tdi_use, ir_sr[IRL-1:1]};
        // [RL13] takes effect here
        SBT_UPD_IR: next_instr = ir_sr;
        SBT_CAP_DR: begin
          if (sel_id) begin
            // [RL11] hardwired code
            // [RL23] presence bit forced
            next_id_sr = ID_CODE | IDL'(1) << `SBT_ID_PRESENT_BIT;
          end else if (sel_bsr) begin
            // [RL10] capture ring
            // [RL18] pin snapshot
            next_bsr = ring_s2;
          end else begin
            // [RL9] bypass cleared
            next_bypass_bit = 1'b0;
          end
        end
        SBT_SH_DR: begin
          // [RL6] only the selected register moves
          if (sel_id) begin
            next_id_sr = {tdi_use, id_sr[IDL-1:1]};
          end else if (sel_bsr) begin
            next_bsr = {tdi_use, bsr[BSR_LEN-1:1]};
          end else begin
            next_bypass_bit = tdi_use;
          end
        end
        // [RL19] update-dr has no preload stage to write
        default: begin
        end
      endcase
      // [RL7] identification on entering reset
      if (move_state == SBT_TLR) begin
        next_instr = `SBT_IR_RESET;
      end
    end
  end

  // [RL7] identification after power-up
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      instr      <= `SBT_IR_RESET;
      ir_sr      <= '0;
      bypass_bit <= 1'b0;
      id_sr      <= '0;
      bsr        <= '0;
    end else begin
      instr      <= next_instr;
      ir_sr      <= next_ir_sr;
      bypass_bit <= next_bypass_bit;
      id_sr      <= next_id_sr;
      bsr        <= next_bsr;
    end
  end

  // ========================================================
  // serial output path
  // decided at the rise, queued, and put on the pin at the fall
  wire      in_shift_ir;
  wire      in_shift_dr;
  wire      dr_lsb;
  sbt_out_t out_push;
  sbt_out_t out_head;
  wire      fifo_out_valid;

  assign in_shift_ir    = (move_state == SBT_SH_IR);
  assign in_shift_dr    = (move_state == SBT_SH_DR);
  // [RL16] identification lsb
  // [RL21] bypass alone
  assign dr_lsb         = sel_id  ? next_id_sr[0] :
                          sel_bsr ? next_bsr[0]   : next_bypass_bit;
  // [RL3] leave from lsb
  assign out_push = '{bit_out: in_shift_ir ? next_ir_sr[0] : dr_lsb,
                      drive:   in_shift_ir || in_shift_dr};

  sbt_fifo #(
    .WIDTH ($bits(sbt_out_t)),
    .DEPTH (`SBT_FIFO_DEPTH)
  ) u_out_fifo (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (work),
    .in_ready  (fifo_in_ready),
    .in_data   (out_push),
    .out_valid (fifo_out_valid),
    .out_ready (tck_fall),
    .out_data  (out_head)
  );

  // [RL1] change at fall
  // [RL4] floating from reset and outside shift states
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tdo    <= 1'b0;
      tdo_oe <= 1'b0;
    end else if (tck_fall && fifo_out_valid) begin
      tdo    <= out_head.bit_out;
      tdo_oe <= out_head.drive;
    end
  end

  // ========================================================
  // status towards the memory
  // [RL5] reset leaves memory operation alone
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_out_hiz  <= 1'b0;
      tap_in_reset <= 1'b1;
    end else begin
      mem_out_hiz  <= float_out;
      tap_in_reset <= (state == SBT_TLR);
    end
  end
endmodule

`default_nettype wire

/* File: rtl/sbt_consts.svh */
`ifndef SBT_CONSTS_SVH
`define SBT_CONSTS_SVH

// ==========================================================
// register widths
`define SBT_IR_LEN          3
`define SBT_ID_LEN          32
`define SBT_BSR_LEN_X36     71
`define SBT_BSR_LEN_X18     52
`define SBT_BSR_LEN_X72     110

// ==========================================================
// instruction codes
`define SBT_INS_EXTEST      3'h0
`define SBT_INS_IDCODE      3'h1
`define SBT_INS_SAMPLE_Z    3'h2
`define SBT_INS_SAMPLE      3'h4
`define SBT_INS_BYPASS      3'h7

// ==========================================================
// capture and reset values
`define SBT_IR_CAPTURE      3'h1
`define SBT_IR_RESET        `SBT_INS_IDCODE
// arbitrary identification value, bit 0 is the presence flag
`define SBT_ID_CODE_DEFAULT 32'h1A2B_0001
`define SBT_ID_PRESENT_BIT  0

// ==========================================================
// buffering and clocks
`define SBT_FIFO_DEPTH      4
`define SBT_REF_CLK_MHZ     50
`define SBT_TCK_MAX_MHZ     20

`endif

/* File: rtl/sbt_pkg.sv */
`include "sbt_consts.svh"

package sbt_pkg;

  // ========================================================
  // controller states
  typedef enum logic [3:0] {
    SBT_TLR    = 4'b0000,
    SBT_RTI    = 4'b0001,
    SBT_SEL_DR = 4'b0010,
    SBT_CAP_DR = 4'b0011,
    SBT_SH_DR  = 4'b0100,
    SBT_EX1_DR = 4'b0101,
    SBT_PA_DR  = 4'b0110,
    SBT_EX2_DR = 4'b0111,
    SBT_UPD_DR = 4'b1000,
    SBT_SEL_IR = 4'b1001,
    SBT_CAP_IR = 4'b1010,
    SBT_SH_IR  = 4'b1011,
    SBT_EX1_IR = 4'b1100,
    SBT_PA_IR  = 4'b1101,
    SBT_EX2_IR = 4'b1110,
    SBT_UPD_IR = 4'b1111
  } sbt_state_t;

  // ========================================================
  // test pins as sampled
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } sbt_pins_t;

  // one serial output step queued for the falling edge
  typedef struct packed {
    logic bit_out;
    logic drive;
  } sbt_out_t;

endpackage

/* File: bench/sbt_tap_properties.sv */
`timescale 1ns/100ps
`default_nettype none
// ========================================
// port checker for the test access port
module sbt_tap_properties #(
  parameter int BSR_LEN = 71
) (
  input wire logic               ref_clk,
  input wire logic               rst,
  input wire logic               tck,
  input wire logic               tms,
  input wire logic               tdi,
  input wire logic [BSR_LEN-1:0] io_ring,
  input wire logic               tdo,
  input wire logic               tdo_oe,
  input wire logic               mem_out_hiz,
  input wire logic               tap_in_reset
);
  logic       tck_q;
  logic       last_tms;
  logic [2:0] ones;
  wire        rise = tck && !tck_q;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // pin-level rise seen ahead of the design's synchroniser
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tck_q    <= 1'h0;
      last_tms <= 1'h1;
      ones     <= 3'h0;
    end else begin
      tck_q <= tck;
      if (rise) begin
        last_tms <= tms;
        ones     <= !tms ? 3'h0 : (ones == 3'h7 ? ones : ones + 3'h1);
      end
    end
  end
  sequence out_hold_s;
    $stable({tdo, tdo_oe})[*6];
  endsequence
  sequence in_tlr_s;
    tap_in_reset[*8];
  endsequence
  fall_only_a: assert property (
    $changed({tdo, tdo_oe}) |-> !$past(tck, 3)) else $error("tdo moved on rise");
  out_hold_a: assert property (
    $changed({tdo, tdo_oe}) |=> out_hold_s) else $error("tdo not held");
  reset_vals_a: assert property (
    $fell(rst) |-> tap_in_reset && !tdo_oe && !mem_out_hiz)
    else $error("bad reset values");
  five_ones_a: assert property (
    rise && tms && ones >= 3'h4 |-> ##[1:8] tap_in_reset)
    else $error("no reset after five ones");
  reset_exit_a: assert property (
    rise && !tms && tap_in_reset |-> ##[1:8] !tap_in_reset)
    else $error("reset state not left");
  reset_ir_a: assert property (
    in_tlr_s |-> !mem_out_hiz) else $error("reset instruction floats");
  oe_tlr_a: assert property (
    tap_in_reset |-> !tdo_oe) else $error("tdo driven in reset");
  oe_on_a: assert property (
    $rose(tdo_oe) |-> !$past(last_tms)) else $error("drive without tms low");
  oe_off_a: assert property (
    $fell(tdo_oe) |-> $past(last_tms)) else $error("release without tms high");
endmodule

bind sbt_tap sbt_tap_properties #(.BSR_LEN(BSR_LEN)) u_props (
  .ref_clk(ref_clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
  .io_ring(io_ring), .tdo(tdo), .tdo_oe(tdo_oe),
  .mem_out_hiz(mem_out_hiz), .tap_in_reset(tap_in_reset));
`default_nettype wire

/* File: bench/sbt_jtag_host.sv */
`timescale 1ns/100ps
`default_nettype none
// ========================================
// boundary-scan controller model
module sbt_jtag_host (
  input  wire logic ref_clk,
  input  wire logic tdo,
  output var logic  tck,
  output var logic  tms,
  output var logic  tdi
);
  // idle at the pull-up level, clock parked low between frames
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h1;
  end
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    repeat (4) @(negedge ref_clk);
    o = tdo;
    tck = 1'h1;
    repeat (4) @(negedge ref_clk);
    tck = 1'h0;
  endtask
endmodule
`default_nettype wire

/* File: bench/sbt_tap_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`include "sbt_consts.svh"
module sbt_tap_tb_top;
  import sbt_pkg::*;
  localparam int BSR = `SBT_BSR_LEN_X36;
  // arbitrary code, bit 0 left clear so the forced flag shows
  localparam logic [31:0] ID = 32'h2C4E_6A8A;
  localparam logic [2:0] CODES [5] = '{`SBT_INS_EXTEST, `SBT_INS_IDCODE,
    `SBT_INS_SAMPLE_Z, `SBT_INS_SAMPLE, `SBT_INS_BYPASS};
  logic           ref_clk, rst, tck, tms, tdi;
  logic           tdo, tdo_oe, mem_out_hiz, tap_in_reset;
  logic [BSR-1:0] io_ring;
  wire            tdo_pin = tdo_oe ? tdo : 1'hz;
  int             failures, n_checks, seed, len;
  sbt_state_t     st;
  logic [2:0]     ir;
  logic [127:0]   sr;
  logic [95:0]    rnd;

  sbt_tap #(.BSR_LEN(BSR), .ID_CODE(ID)) uut (.ref_clk(ref_clk), .rst(rst),
    .tck(tck), .tms(tms), .tdi(tdi), .io_ring(io_ring), .tdo(tdo),
    .tdo_oe(tdo_oe), .mem_out_hiz(mem_out_hiz), .tap_in_reset(tap_in_reset));
  sbt_jtag_host host (.ref_clk(ref_clk), .tdo(tdo_pin), .tck(tck),
    .tms(tms), .tdi(tdi));

  initial begin
    ref_clk = 1'h0;
    forever #10 ref_clk = ~ref_clk;
  end

  function automatic sbt_state_t nxt(sbt_state_t s, logic m);
    case (s)
      SBT_TLR:    return m ? SBT_TLR : SBT_RTI;
      SBT_RTI:    return m ? SBT_SEL_DR : SBT_RTI;
      SBT_SEL_DR: return m ? SBT_SEL_IR : SBT_CAP_DR;
      SBT_SEL_IR: return m ? SBT_TLR : SBT_CAP_IR;
      SBT_CAP_DR, SBT_SH_DR: return m ? SBT_EX1_DR : SBT_SH_DR;
      SBT_CAP_IR, SBT_SH_IR: return m ? SBT_EX1_IR : SBT_SH_IR;
      SBT_EX1_DR: return m ? SBT_UPD_DR : SBT_PA_DR;
      SBT_EX1_IR: return m ? SBT_UPD_IR : SBT_PA_IR;
      SBT_PA_DR:  return m ? SBT_EX2_DR : SBT_PA_DR;
      SBT_PA_IR:  return m ? SBT_EX2_IR : SBT_PA_IR;
      SBT_EX2_DR: return m ? SBT_UPD_DR : SBT_SH_DR;
      SBT_EX2_IR: return m ? SBT_UPD_IR : SBT_SH_IR;
      default:    return m ? SBT_SEL_DR : SBT_RTI;
    endcase
  endfunction

  task automatic chk(input string n, input logic x, input logic g);
    n_checks++;
    if (g !== x) begin
      failures++;
      $display("ERROR %s expected %b seen %b", n, x, g);
    end
  endtask

  task automatic clk1(input logic m, input logic d);
    logic o, r, z, sh;
    sh = st == SBT_SH_DR || st == SBT_SH_IR;
    fork
      host.step(m, d, o);
      begin
        repeat (4) @(negedge ref_clk);
        r = tap_in_reset;
        z = mem_out_hiz;
      end
    join
    chk("tdo", sh ? sr[0] : 1'hz, o);
    chk("tap_in_reset", st == SBT_TLR, r);
    chk("mem_out_hiz", ir == 3'h0 || ir == 3'h2, z);
    case (st)
      SBT_CAP_IR: begin
        sr = 128'h1;
        len = 3;
      end
      SBT_SH_IR, SBT_SH_DR: begin
        sr = sr >> 1;
        sr[len-1] = d;
      end
      SBT_UPD_IR: ir = sr[2:0];
      SBT_CAP_DR: begin
        len = ir == 3'h1 ? 32 : (ir inside {3'h0, 3'h2, 3'h4} ? BSR : 1);
        sr = ir == 3'h1 ? 128'(ID | 32'h1) :
             (len == 1 ? 128'h0 : 128'(io_ring));
      end
      default: ;
    endcase
    st = nxt(st, m);
    if (st == SBT_TLR) ir = `SBT_INS_IDCODE;
  endtask

  task automatic path(input logic [7:0] p, input int n);
    for (int i = 0; i < n; i++) begin
      clk1(p[i], 1'h1);
    end
  endtask

  task automatic load_ir(input logic [2:0] c);
    path(8'h03, 4);
    for (int i = 0; i < 3; i++) begin
      clk1(i == 2, c[i]);
    end
    path(8'h01, 2);
  endtask

  // update-dr passed through with no effect
  task automatic scan_dr(input int n);
    rnd = {$random(seed), $random(seed), $random(seed)};
    io_ring = rnd[BSR-1:0];
    path(8'h01, 3);
    for (int i = 0; i < n; i++) begin
      clk1(i == n - 1, rnd[i % 96]);
    end
    path(8'h01, 2);
  endtask

  task automatic reset_rti();
    path(8'h1F, 6);
  endtask

  task automatic tdone(input string s);
    $display("test %s done", s);
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    seed = 89;
    failures = 0;
    n_checks = 0;
    rst = 1'h1;
    io_ring = '0;
    st = SBT_TLR;
    ir = `SBT_INS_IDCODE;
    sr = '0;
    len = 1;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'h0;
    repeat (4) @(negedge ref_clk);
    reset_rti();
    scan_dr(36);
    tdone("idcode");
    foreach (CODES[k]) begin
      load_ir(CODES[k]);
      repeat (2) scan_dr(BSR + 3);
    end
    tdone("instructions");
    load_ir(`SBT_INS_EXTEST);
    path(8'h01, 3);
    repeat (5) clk1(1'h0, 1'($random(seed)));
    reset_rti();
    scan_dr(36);
    tdone("mid-shift reset");
    // rotating the ir keeps every partial load a defined code
    repeat (300) clk1(1'($random(seed)),
      st == SBT_SH_IR ? sr[0] : 1'($random(seed)));
    tdone("random walk");
    finish_test();
  end

  // about 1250 tck periods of eight cycles are expected
  initial begin
    repeat (40000) @(posedge ref_clk);
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
